/* biphase_pkg.sv */
// shared constants and types for the bi-phase mark audio output framer
package biphase_pkg;

   // subframe and block geometry
   localparam int          SAMPLE_W        = 16;
   localparam logic [4:0]  SLOT_LAST       = 5'h1f;
   localparam logic [4:0]  SLOT_FIRST_DATA = 5'h04;
   localparam logic [8:0]  WORD_LAST       = 9'h17f;   // 384 words per block
   localparam logic [8:0]  WORD_FIRST      = 9'h000;
   localparam logic [7:0]  CS_LAST         = 8'hbf;    // 192 status bits per block

   // preamble level patterns for a low line before the preamble
   localparam logic [7:0]  PRE_B           = 8'he8;
   localparam logic [7:0]  PRE_M           = 8'he2;
   localparam logic [7:0]  PRE_W           = 8'he4;

   // channel-status bit positions
   localparam logic [7:0]  CS_CTRL_LAST    = 8'h03;
   localparam logic [7:0]  CS_CATEGORY     = 8'h08;
   localparam logic [7:0]  CS_ACC_HI       = 8'h1c;
   localparam logic [7:0]  CS_ACC_LO       = 8'h1d;

   // clock accuracy codes
   localparam logic [1:0]  ACC_LEVEL_1     = 2'h2;
   localparam logic [1:0]  ACC_LEVEL_2     = 2'h0;
   localparam logic [1:0]  ACC_LEVEL_3     = 2'h1;

   // register map (byte addresses)
   localparam int          ADDR_W          = 4;
   localparam logic [3:0]  REG_CFG         = 4'h0;
   localparam logic [3:0]  REG_STAT        = 4'h4;

   typedef enum logic [1:0] {MODE_LOW, MODE_PRE, MODE_POST} out_mode_t;

   typedef struct packed {
      logic [1:0] clk_acc;
      logic       cflag_en;
      logic [1:0] mode;
   } cfg_t;

   localparam cfg_t        CFG_RESET       = '{clk_acc: ACC_LEVEL_2, cflag_en: 1'b0, mode: 2'h0};

   typedef struct packed {
      logic [SAMPLE_W-1:0] pre_l;
      logic [SAMPLE_W-1:0] pre_r;
      logic [SAMPLE_W-1:0] post_l;
      logic [SAMPLE_W-1:0] post_r;
      logic [1:0]          err;                   // [1] left, [0] right
      logic [1:0]          correction_flag_info;  // [1] left, [0] right
   } stereo_in_t;

endpackage : biphase_pkg

/* biphase_line_coder.sv */
// bi-phase mark line coder holding the output pin level
`timescale 1ns/10ps
`default_nettype none
module biphase_line_coder (
   // clock and reset
   input  wire logic clk,
   input  wire logic reset,
   input  wire logic ce,
   // half-cell control
   input  wire logic tick,
   input  wire logic force_low,
   input  wire logic sync_start,
   input  wire logic in_sync,
   input  wire logic pat_bit,
   input  wire logic first_half,
   input  wire logic data_bit,
   // line
   output logic      line_ff
);
   logic base_ff;
   logic nxt_line;
   logic nxt_base;
   logic ref_level;

   // preamble polarity follows the level left by the previous parity cell
   assign ref_level = sync_start ? line_ff : base_ff;
   assign nxt_base  = (tick && sync_start) ? line_ff : base_ff;
   assign nxt_line  = force_low  ? 1'b0 :
                      !tick      ? line_ff :
                      in_sync    ? (pat_bit ^ ref_level) :
                      first_half ? ~line_ff :
                      (data_bit ? ~line_ff : line_ff);

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         line_ff <= 1'b0;
         base_ff <= 1'b0;
      end else if (ce) begin
         line_ff <= nxt_line;
         base_ff <= nxt_base;
      end
   end
endmodule : biphase_line_coder
`default_nettype wire

/* biphase_audio_output_framer.sv */
// bi-phase mark digital audio output framer with config/status registers
//
// Contract
// - output modes: forced low, pre-concealment, post-concealment
// - 32-bit subframes, bi-phase mark line code
// - 384-word blocks tracked by word counter
// - slots 0-3 are coding-violating sync preamble
// - B opens block, M other left, W right
// - auxiliary bits 5-7 sent as zero
// - bit 4 carries correction flags when enabled
// - sample in bits 12-27, bits 8-11 zero
// - left and right subframes strictly alternate
// - bit 28 marks uncorrectable samples, both sources
// - bit 29 carries subcode bits, block-unaligned
// - bit 31 gives even parity over 4-31
// - one status bit per pair, 192 per block
// - status bits 0-3 copy checked control bits
// - category bits 8-15 encode compact disc
// - status bits 28-29 carry clock accuracy code
// - output held low while audio features off
// - CD-ROM format means no concealment applied
`timescale 1ns/10ps
`default_nettype none
module biphase_audio_output_framer
   import biphase_pkg::*;
#(
   parameter int HALF_DIV = 35   // clock cycles per half bit cell
) (
   // clock and reset
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // register port
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic [31:0]       wr_data,
   input  wire logic              wr_en,
   input  wire logic              rd_en,
   output logic [31:0]            rd_data_ff,
   // decoder audio stream
   input  wire stereo_in_t        pair_in,
   input  wire logic              pair_valid,
   output logic                   pair_taken_ff,
   // subcode and control
   input  wire logic              subcode_bit,
   output logic                   subcode_taken_ff,
   input  wire logic [3:0]        q_ctrl,
   input  wire logic              q_ctrl_valid,
   input  wire logic              cdrom_mode,
   input  wire logic              audio_features_off,
   // line
   output logic                   biphase_audio_out
);

   if (HALF_DIV < 2 || HALF_DIV > 65536) begin : g_div_check
      $error("HALF_DIV must lie in 2..65536");
   end

   localparam logic [15:0] DIV_LAST = 16'(HALF_DIV - 1);

   cfg_t                cfg_ff;
   logic [15:0]         div_ff;
   logic                half_ff;
   logic [4:0]          slot_ff;
   logic [8:0]          word_cnt_ff;
   logic [31:0]         word_ff;
   stereo_in_t          hold_ff;
   stereo_in_t          cur_ff;
   logic [3:0]          q_ctrl_ff;

   // ------------------------------------------------------------ registers
   wire sel_cfg   = (addr == REG_CFG);
   wire sel_stat  = (addr == REG_STAT);
   wire cfg_write = ce && wr_en && sel_cfg;
   wire [31:0] stat_word = {22'h000000, biphase_audio_out, word_cnt_ff};
   wire [31:0] nxt_rd_data = !rd_en   ? 32'h00000000 :
                             sel_cfg  ? {27'h0000000, cfg_ff} :
                             sel_stat ? stat_word : 32'h00000000;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cfg_ff     <= CFG_RESET;
         rd_data_ff <= 32'h00000000;
      end else if (ce) begin
         if (cfg_write) cfg_ff <= cfg_t'(wr_data[4:0]);
         rd_data_ff <= nxt_rd_data;
      end
   end

   // ------------------------------------------------------------ mode decode
   // the unused mode code behaves as forced low so no stray source is sent
   wire mode_pre   = (cfg_ff.mode == MODE_PRE);
   wire mode_post  = (cfg_ff.mode == MODE_POST);
   wire force_low  = !(mode_pre || mode_post) || audio_features_off;
   // cd-rom formats never see concealed data, whatever the mode says
   wire use_pre    = mode_pre || cdrom_mode;

   // ------------------------------------------------------------ cell timing
   wire tick       = ce && (div_ff == DIV_LAST);
   wire last_cell  = (slot_ff == SLOT_LAST) && half_ff;
   wire word_end   = tick && last_cell;
   wire [8:0] nxt_word_idx = (word_cnt_ff == WORD_LAST) ? WORD_FIRST
                                                        : word_cnt_ff + 9'h001;

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         div_ff      <= 16'h0000;
         half_ff     <= 1'b0;
         slot_ff     <= 5'h00;
         word_cnt_ff <= WORD_FIRST;
      end else if (ce) begin
         div_ff <= tick ? 16'h0000 : div_ff + 16'h0001;
         if (tick) begin
            half_ff <= ~half_ff;
            if (half_ff) slot_ff <= slot_ff + 5'h01;
         end
         if (word_end) word_cnt_ff <= nxt_word_idx;
      end
   end

   // ------------------------------------------------------------ next subframe
   wire        nxt_left  = ~nxt_word_idx[0];
   wire [7:0]  cs_idx    = nxt_word_idx[8:1];
   stereo_in_t src_pair;
   assign src_pair = nxt_left ? hold_ff : cur_ff;

   wire [SAMPLE_W-1:0] pre_smp  = nxt_left ? src_pair.pre_l  : src_pair.pre_r;
   wire [SAMPLE_W-1:0] post_smp = nxt_left ? src_pair.post_l : src_pair.post_r;
   wire [SAMPLE_W-1:0] smp      = use_pre ? pre_smp : post_smp;
   wire ch_err   = nxt_left ? src_pair.err[1] : src_pair.err[0];
   wire ch_correction_flag_info  = nxt_left ? src_pair.correction_flag_info[1]
                            : src_pair.correction_flag_info[0];
   wire aux_bit  = cfg_ff.cflag_en && ch_correction_flag_info;

   wire cs_ctrl  = (cs_idx <= CS_CTRL_LAST) && q_ctrl_ff[cs_idx[1:0]];
   wire cs_cat   = (cs_idx == CS_CATEGORY);
   wire cs_acc   = ((cs_idx == CS_ACC_HI) && cfg_ff.clk_acc[1]) ||
                   ((cs_idx == CS_ACC_LO) && cfg_ff.clk_acc[0]);
   wire cs_bit   = cs_ctrl || cs_cat || cs_acc;

   // slots 0-3 carry no data; the preamble is generated separately
   wire [30:0] body = {cs_bit, subcode_bit, ch_err, smp, 4'h0, 3'h0, aux_bit, 4'h0};
   wire [31:0] nxt_word = {^body[30:4], body};

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         word_ff          <= 32'h00000000;
         hold_ff          <= '0;
         cur_ff           <= '0;
         q_ctrl_ff        <= 4'h0;
         pair_taken_ff    <= 1'b0;
         subcode_taken_ff <= 1'b0;
      end else if (ce) begin
         if (pair_valid) hold_ff <= pair_in;
         if (q_ctrl_valid) q_ctrl_ff <= q_ctrl;
         if (word_end) word_ff <= nxt_word;
         if (word_end && nxt_left) cur_ff <= hold_ff;
         pair_taken_ff    <= word_end && nxt_left;
         subcode_taken_ff <= word_end;
      end
   end

   // ------------------------------------------------------------ line coding
   wire       in_sync    = (slot_ff < SLOT_FIRST_DATA);
   wire       sync_start = (slot_ff == 5'h00) && !half_ff;
   wire [7:0] pattern    = (word_cnt_ff == WORD_FIRST) ? PRE_B :
                           word_cnt_ff[0]              ? PRE_W : PRE_M;
   wire [2:0] pat_pos    = ~{slot_ff[1:0], half_ff};
   wire       pat_bit    = pattern[pat_pos];

   biphase_line_coder u_coder (
      .clk        (clk),
      .reset      (reset),
      .ce         (ce),
      .tick       (tick),
      .force_low  (force_low),
      .sync_start (sync_start),
      .in_sync    (in_sync),
      .pat_bit    (pat_bit),
      .first_half (!half_ff),
      .data_bit   (word_ff[slot_ff]),
      .line_ff    (biphase_audio_out)
   );

   // ------------------------------------------------------------ checks
   logic left_cs_ff;
   always_ff @(posedge clk or posedge reset) begin
      if (reset) left_cs_ff <= 1'b0;
      else if (ce && word_end && nxt_left) left_cs_ff <= cs_bit;
   end

   property p_forced_low;
      @(posedge clk) disable iff (reset)
      (ce && cfg_ff.mode == MODE_LOW) |=> !biphase_audio_out;
   endproperty
   a_forced_low: assert property (p_forced_low) else $error("line not low in forced mode");

   property p_first_half_toggle;
      @(posedge clk) disable iff (reset)
      (tick && !force_low && !in_sync && !half_ff) |=> biphase_audio_out != $past(biphase_audio_out);
   endproperty
   a_first_half_toggle: assert property (p_first_half_toggle) else $error("no cell-edge transition");

   property p_zero_no_mid;
      @(posedge clk) disable iff (reset)
      (tick && !force_low && !in_sync && half_ff && !word_ff[slot_ff])
         |=> biphase_audio_out == $past(biphase_audio_out);
   endproperty
   a_zero_no_mid: assert property (p_zero_no_mid) else $error("zero cell has mid transition");

   property p_block_range;
      @(posedge clk) disable iff (reset)
      word_end && (word_cnt_ff == WORD_LAST) |=> word_cnt_ff == WORD_FIRST;
   endproperty
   a_block_range: assert property (p_block_range) else $error("block counter did not wrap at 384");

   property p_sync_preamble;
      @(posedge clk) disable iff (reset)
      (tick && !force_low && sync_start) |=> biphase_audio_out != $past(biphase_audio_out)
         ##2 biphase_audio_out == $past(biphase_audio_out, 2);
   endproperty
   a_sync_preamble: assert property (p_sync_preamble) else $error("preamble opening wrong");

   property p_preamble_kind;
      @(posedge clk) disable iff (reset)
      sync_start |-> (pattern == PRE_B) == (word_cnt_ff == WORD_FIRST)
                     && ((pattern == PRE_W) == word_cnt_ff[0]);
   endproperty
   a_preamble_kind: assert property (p_preamble_kind) else $error("preamble kind wrong");

   property p_aux_zero;
      @(posedge clk) disable iff (reset)
      (word_end && !cfg_ff.cflag_en) |=> word_ff[7:4] == 4'h0 && word_ff[11:8] == 4'h0;
   endproperty
   a_aux_zero: assert property (p_aux_zero) else $error("auxiliary or pad bits not zero");

   property p_sample_place;
      @(posedge clk) disable iff (reset)
      word_end |=> word_ff[27:12] == $past(smp) && word_ff[28] == $past(ch_err);
   endproperty
   a_sample_place: assert property (p_sample_place) else $error("sample or validity misplaced");

   property p_parity;
      @(posedge clk) disable iff (reset)
      word_end |=> ^word_ff[31:4] == 1'b0;
   endproperty
   a_parity: assert property (p_parity) else $error("parity not even");

   property p_cs_pair;
      @(posedge clk) disable iff (reset)
      (word_end && !nxt_left) |=> word_ff[30] == left_cs_ff;
   endproperty
   a_cs_pair: assert property (p_cs_pair) else $error("status bit differs in pair");

   property p_category;
      @(posedge clk) disable iff (reset)
      (word_end && cs_idx == CS_CATEGORY) |=> word_ff[30];
   endproperty
   a_category: assert property (p_category) else $error("category bit not set");

   property p_accuracy;
      @(posedge clk) disable iff (reset)
      (word_end && cs_idx == CS_ACC_HI) |=> word_ff[30] == $past(cfg_ff.clk_acc[1]);
   endproperty
   a_accuracy: assert property (p_accuracy) else $error("clock accuracy bit wrong");

   property p_pre_source;
      @(posedge clk) disable iff (reset)
      (word_end && cdrom_mode) |=> word_ff[27:12] == $past(pre_smp);
   endproperty
   a_pre_source: assert property (p_pre_source) else $error("concealed data in cd-rom format");

   // the second half-cell of the preamble keeps its level into the next cell
   property p_sync_break;
      @(posedge clk) disable iff (reset)
      (tick && !force_low && in_sync && slot_ff[1:0] == 2'h1 && !half_ff)
         |=> biphase_audio_out == $past(biphase_audio_out);
   endproperty
   a_sync_break: assert property (p_sync_break) else $error("no preamble violation");

   property p_cflag_bit;
      @(posedge clk) disable iff (reset)
      (word_end && cfg_ff.cflag_en) |=> word_ff[4] == $past(ch_correction_flag_info);
   endproperty
   a_cflag_bit: assert property (p_cflag_bit) else $error("flag bit not sent");

   property p_alternate;
      @(posedge clk) disable iff (reset)
      pair_taken_ff |-> !word_cnt_ff[0];
   endproperty
   a_alternate: assert property (p_alternate) else $error("pair taken for a right word");

   property p_subcode_place;
      @(posedge clk) disable iff (reset)
      word_end |=> word_ff[29] == $past(subcode_bit) && subcode_taken_ff;
   endproperty
   a_subcode_place: assert property (p_subcode_place) else $error("user bit misplaced");

   property p_ctrl_copy;
      @(posedge clk) disable iff (reset)
      (word_end && cs_idx == 8'h02) |=> word_ff[30] == $past(q_ctrl_ff[2]);
   endproperty
   a_ctrl_copy: assert property (p_ctrl_copy) else $error("copy status bit wrong");

   property p_cat_zero;
      @(posedge clk) disable iff (reset)
      (word_end && cs_idx > CS_CATEGORY && cs_idx < CS_ACC_HI) |=> !word_ff[30];
   endproperty
   a_cat_zero: assert property (p_cat_zero) else $error("status bits 9-27 not zero");

   property p_cs_zero;
      @(posedge clk) disable iff (reset)
      (word_end && cs_idx > CS_ACC_LO) |=> !word_ff[30];
   endproperty
   a_cs_zero: assert property (p_cs_zero) else $error("upper status bits not zero");

   property p_features_off;
      @(posedge clk) disable iff (reset)
      (ce && audio_features_off) |=> !biphase_audio_out;
   endproperty
   a_features_off: assert property (p_features_off) else $error("line not low");

   property p_slot_order;
      @(posedge clk) disable iff (reset)
      (tick && half_ff) |=> slot_ff == $past(slot_ff) + 5'h01;
   endproperty
   a_slot_order: assert property (p_slot_order) else $error("slot not ascending");

   c_block_wrap: cover property (@(posedge clk) disable iff (reset)
      word_end && word_cnt_ff == WORD_LAST);
   c_post_mode:  cover property (@(posedge clk) disable iff (reset)
      word_end && mode_post && !cdrom_mode);
   c_cflag_sent: cover property (@(posedge clk) disable iff (reset)
      word_end ##1 word_ff[4]);
   c_cdrom:      cover property (@(posedge clk) disable iff (reset)
      word_end && cdrom_mode && mode_pre);
   // features off while a live mode is selected
   c_feat_off:   cover property (@(posedge clk) disable iff (reset)
      ce && audio_features_off && mode_post);

endmodule : biphase_audio_output_framer
`default_nettype wire

/* biphase_rx_model.sv */
// receiving end of the bi-phase line: recovers preambles and subframe slots
`timescale 1ns/10ps
`default_nettype none
module biphase_rx_model
   import biphase_pkg::*;
#(
   parameter int HALF_DIV = 2
) (
   // clock
   input  wire logic   clk,
   // line
   input  wire logic   line,
   // recovered subframe
   output logic        rx_stb,
   output logic [1:0]  rx_pre,
   output logic [31:0] rx_word,
   output logic        rx_bad
);
   logic [63:0] hist = '0;
   logic [7:0]  pat;
   logic        last = 1'b0;
   logic        infr = 1'b0;
   int          ph = 0;
   int          cnt = 0;

   // half-cell grid is re-aligned on every edge, sampled mid-cell
   always @(posedge clk) begin
      rx_stb <= 1'b0;
      if (line !== last)
         ph = 0;
      else
         ph = (ph == HALF_DIV - 1) ? 0 : ph + 1;
      last = line;
      if (ph == HALF_DIV / 2) begin
         hist = {hist[62:0], line};
         pat = hist[8] ? ~hist[7:0] : hist[7:0];
         if (infr) begin
            cnt = cnt + 1;
            if (cnt == 56) begin
               infr = 1'b0;
               rx_bad <= 1'b0;
               rx_word[3:0] <= 4'h0;
               for (int j = 0; j < 28; j++) begin
                  rx_word[4+j] <= hist[55-2*j] ^ hist[54-2*j];
                  if (hist[56-2*j] == hist[55-2*j])
                     rx_bad <= 1'b1;
               end
               rx_stb <= 1'b1;
            end
         end else if (pat == PRE_B || pat == PRE_M || pat == PRE_W) begin
            infr = 1'b1;
            cnt = 0;
            rx_pre <= (pat == PRE_B) ? 2'h0 : (pat == PRE_M) ? 2'h1 : 2'h2;
         end
      end
   end
endmodule : biphase_rx_model
`default_nettype wire

/* tb_biphase_audio_output_framer.sv */
// self-checking bench for the bi-phase audio output framer
`timescale 1ns/10ps
`default_nettype none
module tb_biphase_audio_output_framer
   import biphase_pkg::*;
;
   localparam int         H     = 2;
   localparam int         FRAME = 64 * H;
   localparam logic [3:0] Q     = 4'hd;
   localparam stereo_in_t PA    = '{16'h8001, 16'h7ffe, 16'h1234, 16'hedcb, 2'h2, 2'h1};
   localparam stereo_in_t PB    = '{16'h0f0f, 16'hf0f0, 16'h5555, 16'haaaa, 2'h1, 2'h2};
   logic              clk, reset, ce, wr_en, rd_en, pair_valid, q_ctrl_valid;
   logic              subcode_bit, subcode_taken_ff, cdrom_mode, audio_features_off;
   logic              biphase_audio_out, rx_stb, rx_bad, cur_en, pair_taken_ff, pt_seen;
   logic              chk_on = 1'b0;
   logic              kvalid = 1'b0;
   logic [ADDR_W-1:0] addr;
   logic [31:0]       wr_data, rd_data_ff, rx_word;
   logic [3:0]        q_ctrl;
   logic [1:0]        rx_pre, cur_mode, cur_acc;
   logic [1:0]        sc_hist = 2'h0;
   stereo_in_t        pair_in, cur_pair;
   int                n_mismatch = 0;
   int                cmp_count = 0;
   int                k = 0;
   int                nk, gap;

   biphase_audio_output_framer #(.HALF_DIV(H)) u_dut (
      .clk, .reset, .ce, .addr, .wr_data, .wr_en, .rd_en, .rd_data_ff, .pair_in,
      .pair_valid, .pair_taken_ff, .subcode_bit, .subcode_taken_ff, .q_ctrl,
      .q_ctrl_valid, .cdrom_mode, .audio_features_off, .biphase_audio_out);

   biphase_rx_model #(.HALF_DIV(H)) u_rx (
      .clk, .line(biphase_audio_out), .rx_stb, .rx_pre, .rx_word, .rx_bad);

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask : chk

   task automatic complete_run();
      $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : complete_run

   task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
      @(posedge clk);
      addr    <= a;
      wr_data <= d;
      wr_en   <= 1'b1;
      @(posedge clk);
      wr_en   <= 1'b0;
   endtask : bus_wr

   task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [31:0] d);
      @(posedge clk);
      addr  <= a;
      rd_en <= 1'b1;
      @(posedge clk);
      rd_en <= 1'b0;
      #1;
      d = rd_data_ff;
   endtask : bus_rd

   task automatic low_span(input int n);
      int hits;
      hits = 0;
      repeat (2) @(posedge clk);
      repeat (n) begin
         @(posedge clk);
         #1;
         if (biphase_audio_out !== 1'b0)
            hits++;
      end
      chk("line low", 32'(hits), 32'h0);
   endtask : low_span

   task automatic wait_frames(input int n);
      int t;
      repeat (n) begin
         t = 0;
         do begin
            @(posedge clk);
            #1;
            t++;
         end while (rx_stb !== 1'b1 && t < 2 * FRAME);
         chk("frame", {31'h0, rx_stb}, 32'h1);
      end
   endtask : wait_frames

   function automatic logic cs_bit(input int i);
      if (i < 4)
         return Q[i];
      if (i == 8)
         return 1'b1;
      if (i == 28)
         return cur_acc[1];
      if (i == 29)
         return cur_acc[0];
      return 1'b0;
   endfunction : cs_bit

   function automatic logic [31:0] exp_word(input logic right, input logic st);
      logic [31:0] w;
      logic        post;
      post = (cur_mode == 2'h2) && !cdrom_mode;
      w = '0;
      w[4] = cur_en & (right ? cur_pair.correction_flag_info[0] : cur_pair.correction_flag_info[1]);
      if (right)
         w[27:12] = post ? cur_pair.post_r : cur_pair.pre_r;
      else
         w[27:12] = post ? cur_pair.post_l : cur_pair.pre_l;
      w[28] = right ? cur_pair.err[0] : cur_pair.err[1];
      w[29] = sc_hist[1];
      w[30] = st;
      w[31] = ^w[30:4];
      return w;
   endfunction : exp_word

   // subframe judged against the bit sampled one load earlier: the next load has already happened
   always @(posedge clk) begin
      gap <= gap + 1;
      if (subcode_taken_ff === 1'b1) begin
         sc_hist     <= {sc_hist[0], subcode_bit};
         subcode_bit <= ~subcode_bit;
         pt_seen     <= pair_taken_ff;
      end
      if (rx_stb === 1'b1) begin
         gap <= 0;
         nk = (k == 383) ? 0 : k + 1;
         k = nk;
         if (gap > FRAME + 8)
            kvalid = 1'b0;
         if (chk_on && kvalid) begin
            chk("preamble", {30'h0, rx_pre}, (nk == 0) ? 32'h0 : 32'(nk % 2 + 1));
            chk("status", {31'h0, rx_word[30]}, {31'h0, cs_bit(nk / 2)});
            chk("pair taken", {31'h0, pt_seen}, 32'(nk % 2));
         end
         if (chk_on)
            chk("subframe", rx_word | {31'h0, rx_bad}, exp_word(rx_pre == 2'h2, rx_word[30]));
      end
   end

   task automatic t_reset();
      logic [31:0] d;
      #1;
      chk("rd data", rd_data_ff, 32'h0);
      bus_rd(REG_CFG, d);
      chk("cfg", d, 32'(CFG_RESET));
      bus_rd(REG_STAT, d);
      chk("stat line", {31'h0, d[9]}, 32'h0);
      low_span(3 * FRAME);
   endtask : t_reset

   task automatic t_regs();
      logic [31:0] d;
      bus_wr(REG_CFG, 32'hffff_ff1f);
      bus_rd(REG_CFG, d);
      chk("cfg", d, 32'h1f);
      @(posedge clk);
      #1;
      chk("rd idle", rd_data_ff, 32'h0);
      bus_wr(4'hc, 32'h0);
      bus_rd(4'h8, d);
      chk("unmapped", d, 32'h0);
      bus_rd(REG_CFG, d);
      chk("cfg kept", d, 32'h1f);
      // a write strobe while the enable is low must be lost
      ce <= 1'b0;
      bus_wr(REG_CFG, 32'h2);
      ce <= 1'b1;
      bus_rd(REG_CFG, d);
      chk("ce hold", d, 32'h1f);
      low_span(2 * FRAME);
   endtask : t_regs

   task automatic t_stream(input logic [1:0] m, input logic en, input logic [1:0] acc,
                           input logic cd, input stereo_in_t p, input int n);
      logic [31:0] d;
      chk_on = 1'b0;
      @(posedge clk);
      pair_in    <= p;
      pair_valid <= 1'b1;
      cdrom_mode <= cd;
      @(posedge clk);
      pair_valid <= 1'b0;
      cur_pair = p;
      cur_mode = m;
      cur_en = en;
      cur_acc = acc;
      bus_wr(REG_CFG, {27'h0, acc, en, m});
      wait_frames(3);
      // the word on the line is the next one to arrive
      bus_rd(REG_STAT, d);
      k = (d[8:0] == 9'h0) ? 383 : int'(d[8:0]) - 1;
      kvalid = 1'b1;
      chk_on = 1'b1;
      wait_frames(n);
      chk_on = 1'b0;
   endtask : t_stream

   task automatic t_feat_off();
      bus_wr(REG_CFG, 32'h0);
      audio_features_off <= 1'b1;
      bus_wr(REG_CFG, 32'h2);
      low_span(2 * FRAME);
      bus_wr(REG_CFG, 32'h0);
      audio_features_off <= 1'b0;
   endtask : t_feat_off

   initial begin
      reset = 1'b1;
      ce = 1'b1;
      addr = '0;
      wr_data = '0;
      wr_en = 1'b0;
      rd_en = 1'b0;
      pair_in = PA;
      pair_valid = 1'b0;
      subcode_bit = 1'b0;
      q_ctrl = Q;
      q_ctrl_valid = 1'b0;
      cdrom_mode = 1'b0;
      audio_features_off = 1'b0;
      repeat (16) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      @(posedge clk);
      q_ctrl_valid <= 1'b1;
      @(posedge clk);
      q_ctrl_valid <= 1'b0;
      t_regs();
      t_stream(2'h2, 1'b1, ACC_LEVEL_1, 1'b0, PA, 400);
      t_stream(2'h1, 1'b0, ACC_LEVEL_3, 1'b1, PB, 12);
      t_stream(2'h2, 1'b1, ACC_LEVEL_2, 1'b1, PB, 12);
      t_feat_off();
      complete_run();
   end

   initial begin
      repeat (90000) @(posedge clk);
      n_mismatch++;
      complete_run();
   end
endmodule : tb_biphase_audio_output_framer
`default_nettype wire
